/* File: hw/spiq_pkg.sv */
// Purpose: Shared constants and types for the SPI controller block.
// Assumes: Eight-bit frames, chip selects addressed by a binary index.
// Notes: Widths, reset values and state codes used by the logic live here.
package spiq_pkg;
    localparam int SPIQ_NCS = 4;
    localparam int PCS_W = 2;
    localparam int DATA_W = 8;
    localparam int DIV_W = 8;
    localparam int EDGE_W = 4;
    // ========================================================
    // Frame shape and reset values
    localparam logic [EDGE_W-1:0] EDGE_LAST = 4'hf;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [PCS_W-1:0] PCS_RST = 2'h0;
    localparam logic TX_HOLDING_EMPTY_FLAG_RST = 1'b1;
    localparam int RXW_W = DATA_W + PCS_W;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXTRA,
        ST_SHIFT,
        ST_DONE
    } spiq_state_t;
endpackage

/* File: hw/spiq_stream_if.sv */
// Purpose: Valid/ready word carrier between the engine and its buffer.
// Assumes: One clock domain; a word moves when valid and ready are high.
// Notes: The clear line empties the buffer on soft reset.
`timescale 1ns/1ps
interface spiq_stream_if #(parameter int W = 10);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    logic clr;

    modport src (output valid, output data, output clr, input ready);
    modport snk (input valid, input data, input clr, output ready);
    modport drn (input ready, output valid, output data);
endinterface

/* File: hw/spiq_buf2.sv */
// Purpose: Two-entry buffer on the received-word path.
// Assumes: Fill side and drain side share the clock.
// Notes: Output word comes straight from the head register.
`timescale 1ns/1ps
module spiq_buf2 #(
    parameter int W = 10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    spiq_stream_if.snk in_if,
    spiq_stream_if.drn out_if
);
    import spiq_pkg::*;

    logic [W-1:0] head_r;
    logic [W-1:0] tail_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign in_if.ready = (cnt_r != 2'h2);
    assign out_if.valid = (cnt_r != 2'h0);
    assign out_if.data = head_r;
    assign push = in_if.valid & in_if.ready;
    assign pop = out_if.valid & out_if.ready;

    // ========================================================
    // Occupancy
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_r <= 2'h0;
        else if (in_if.clr)
            cnt_r <= 2'h0;
        else if (push && !pop)
            cnt_r <= cnt_r + 2'h1;
        else if (pop && !push)
            cnt_r <= cnt_r - 2'h1;
    end

    // ========================================================
    // Storage
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            head_r <= '0;
            tail_r <= '0;
        end
        else if (pop)
        begin
            head_r <= (cnt_r == 2'h1) ? in_if.data : tail_r;
            if (push && cnt_r == 2'h2)
                tail_r <= in_if.data;
        end
        else if (push)
        begin
            if (cnt_r == 2'h0)
                head_r <= in_if.data;
            else
                tail_r <= in_if.data;
        end
    end
endmodule

/* File: hw/spiq_core.sv */
// Purpose: SPI master/slave controller with this revision's quirks.
// Assumes: Serial pins are asynchronous and pass two flip-flops.
// Notes: Control and status are plain ports, one-cycle command pulses.
// Function
// - Chip select 0 hold with mode fault detection enabled blocks every master transfer.
// - Disabling leaves the transmit-holding-empty flag as it was.
// - Writes while disabled are dropped and keep the empty flag.
// - DMA words written after a disable are all lost.
// - Disable command is ignored in slave mode.
// - Soft reset bit resets the controller; used to leave slave mode.
// - Mixed divisor one and not one with polarity 1, phase 0 adds a pulse.
// - Received select field does not track the select pins.
`timescale 1ns/1ps
module spiq_core #(
    parameter int NCS = spiq_pkg::SPIQ_NCS
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic enable_cmd_i,
    input wire logic disable_cmd_i,
    input wire logic soft_reset_bit_i,
    input wire logic master_mode_i,
    input wire logic mode_fault_detect_disable_i,
    input wire logic [NCS-1:0] cs_hold_after_transfer_i,
    input wire logic [NCS-1:0] cpol_i,
    input wire logic [NCS-1:0] inverted_phase_bit_i,
    input wire logic [NCS*spiq_pkg::DIV_W-1:0] sck_divisor_i,
    input wire logic tx_wr_i,
    input wire logic [spiq_pkg::DATA_W-1:0] tx_data_i,
    input wire logic [spiq_pkg::PCS_W-1:0] tx_pcs_i,
    output logic tx_holding_empty_flag_o,
    output logic enabled_o,
    output logic mode_fault_o,
    output logic overrun_o,
    output logic busy_o,
    output logic rx_valid_o,
    output logic [spiq_pkg::DATA_W-1:0] rx_data_o,
    output logic [spiq_pkg::PCS_W-1:0] periph_select_field_o,
    input wire logic rx_ready_i,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic ss_n_i,
    output logic [NCS-1:0] chip_select_pins_o
);
    import spiq_pkg::*;

    spiq_stream_if #(.W(RXW_W)) fill_if ();
    spiq_stream_if #(.W(RXW_W)) drain_if ();

    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic sck_d_r;
    logic ss_d_r;
    logic enabled_r;
    logic mode_fault_r;
    logic overrun_r;
    logic tx_holding_empty_flag_r;
    logic [DATA_W-1:0] tx_holding_reg_r;
    logic [PCS_W-1:0] thr_pcs_r;
    logic [DATA_W-1:0] shreg_r;
    logic [DATA_W-1:0] rxs_r;
    logic [DATA_W-1:0] rx_nxt;
    spiq_state_t st_r;
    logic [PCS_W-1:0] cur_cs_r;
    logic [PCS_W-1:0] last_cs_r;
    logic last_vld_r;
    logic cs_on_r;
    logic sck_r;
    logic [DIV_W-1:0] divcnt_r;
    logic [EDGE_W-1:0] edge_r;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    logic srst;
    logic hang;
    logic tx_accept;
    logic start;
    logic need_extra;
    logic tick;
    logic edge_go;
    logic cpha;
    logic sample;
    logic shift;
    logic word_done;
    logic slave_act;
    logic sl_edge;
    logic sl_load;
    logic load;
    logic mf_evt;
    logic in_bit;

    function automatic logic [DIV_W-1:0] div_of(input logic [PCS_W-1:0] i,
        input logic [NCS*DIV_W-1:0] v);
        logic [DIV_W-1:0] d;
        d = v[i*DIV_W +: DIV_W];
        return (d == DIV_ZERO) ? DIV_ONE : d;
    endfunction

    // ========================================================
    // Pin synchronisers: sck, mosi, miso, ss_n
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_r <= 4'h1;
            s2_r <= 4'h1;
            sck_d_r <= 1'b0;
            ss_d_r <= 1'b1;
        end
        else
        begin
            s1_r <= {sck_i, mosi_i, miso_i, ss_n_i};
            s2_r <= s1_r;
            sck_d_r <= s2_r[3];
            ss_d_r <= s2_r[0];
        end
    end
    assign sck_s = s2_r[3];
    assign mosi_s = s2_r[2];
    assign miso_s = s2_r[1];
    assign ss_s = s2_r[0];

    // ========================================================
    // Control decode
    assign srst = soft_reset_bit_i;
    assign hang = cs_hold_after_transfer_i[0]
        & ~mode_fault_detect_disable_i;
    assign tx_accept = tx_wr_i & enabled_r;
    assign mf_evt = master_mode_i & enabled_r
        & ~mode_fault_detect_disable_i & ~ss_s;
    assign start = master_mode_i & enabled_r & ~tx_holding_empty_flag_r & ~hang
        & (st_r == ST_IDLE) & fill_if.ready;
    assign need_extra = last_vld_r & (last_cs_r != thr_pcs_r)
        & cpol_i[thr_pcs_r] & ~inverted_phase_bit_i[thr_pcs_r]
        & ((div_of(last_cs_r, sck_divisor_i) == DIV_ONE)
        != (div_of(thr_pcs_r, sck_divisor_i) == DIV_ONE));
    assign tick = ((st_r == ST_EXTRA) || (st_r == ST_SHIFT))
        && (divcnt_r == div_of(cur_cs_r, sck_divisor_i) - DIV_ONE);
    assign slave_act = ~master_mode_i & enabled_r & ~ss_s;
    assign sl_edge = slave_act & (sck_s != sck_d_r);
    assign edge_go = ((st_r == ST_SHIFT) & tick) | sl_edge;
    assign cpha = ~inverted_phase_bit_i[master_mode_i ? cur_cs_r : PCS_RST];
    assign sample = edge_go & (edge_r[0] == cpha);
    assign shift = edge_go & (edge_r[0] != cpha) & (edge_r != '0);
    assign word_done = edge_go & (edge_r == EDGE_LAST);
    assign sl_load = ~master_mode_i & enabled_r
        & ((ss_d_r & ~ss_s) | (sl_edge & (edge_r == EDGE_LAST)));
    assign load = start | sl_load;
    assign in_bit = master_mode_i ? miso_s : mosi_s;
    assign rx_nxt = sample ? {rxs_r[DATA_W-2:0], in_bit} : rxs_r;

    // ========================================================
    // Enable and sticky error flags
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            enabled_r <= 1'b0;
        else if (srst)
            enabled_r <= 1'b0;
        else if (mf_evt)
            enabled_r <= 1'b0;
        else if (disable_cmd_i && master_mode_i)
            enabled_r <= 1'b0;
        else if (enable_cmd_i)
            enabled_r <= 1'b1;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_fault_r <= 1'b0;
            overrun_r <= 1'b0;
        end
        else if (srst)
        begin
            mode_fault_r <= 1'b0;
            overrun_r <= 1'b0;
        end
        else
        begin
            // Set beats the clear done by a fresh enable
            mode_fault_r <= mf_evt | (mode_fault_r & ~enable_cmd_i);
            overrun_r <= (slave_act & word_done & ~fill_if.ready)
                | (overrun_r & ~enable_cmd_i);
        end
    end

    // ========================================================
    // Transmit holding register; disable never touches the flag
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_holding_empty_flag_r <= TX_HOLDING_EMPTY_FLAG_RST;
            tx_holding_reg_r <= DATA_RST;
            thr_pcs_r <= PCS_RST;
        end
        else if (srst)
        begin
            tx_holding_empty_flag_r <= TX_HOLDING_EMPTY_FLAG_RST;
            tx_holding_reg_r <= DATA_RST;
            thr_pcs_r <= PCS_RST;
        end
        else if (tx_accept)
        begin
            tx_holding_empty_flag_r <= 1'b0;
            tx_holding_reg_r <= tx_data_i;
            thr_pcs_r <= tx_pcs_i;
        end
        else if (load)
            tx_holding_empty_flag_r <= 1'b1;
    end

    // ========================================================
    // Shift registers, shared by master and slave
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shreg_r <= DATA_RST;
            rxs_r <= DATA_RST;
        end
        else if (srst)
        begin
            shreg_r <= DATA_RST;
            rxs_r <= DATA_RST;
        end
        else
        begin
            rxs_r <= rx_nxt;
            // Slave with nothing queued sends zeros
            if (load)
                shreg_r <= tx_holding_empty_flag_r ? DATA_RST : tx_holding_reg_r;
            else if (shift)
                shreg_r <= {shreg_r[DATA_W-2:0], 1'b0};
        end
    end

    // ========================================================
    // Master sequencer
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= ST_IDLE;
        else if (srst || (master_mode_i && !enabled_r))
            st_r <= ST_IDLE;
        else
            unique case (st_r)
                ST_IDLE:
                    if (start)
                        st_r <= need_extra ? ST_EXTRA : ST_SHIFT;
                ST_EXTRA:
                    if (tick && edge_r[0])
                        st_r <= ST_SHIFT;
                ST_SHIFT:
                    if (word_done)
                        st_r <= ST_DONE;
                ST_DONE:
                    if (fill_if.ready)
                        st_r <= ST_IDLE;
            endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            divcnt_r <= DIV_ZERO;
            edge_r <= '0;
        end
        else if (srst || start || tick || (!master_mode_i && ss_s))
        begin
            divcnt_r <= DIV_ZERO;
            if (srst || start || (!master_mode_i && ss_s)
                || (st_r == ST_EXTRA && edge_r[0]))
                edge_r <= '0;
            else
                edge_r <= edge_r + 4'h1;
        end
        else
        begin
            divcnt_r <= divcnt_r + DIV_ONE;
            if (sl_edge)
                edge_r <= edge_r + 4'h1;
        end
    end

    // ========================================================
    // Select, clock level and divisor history
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur_cs_r <= PCS_RST;
            last_cs_r <= PCS_RST;
            last_vld_r <= 1'b0;
            cs_on_r <= 1'b0;
            sck_r <= 1'b0;
        end
        else if (srst)
        begin
            cur_cs_r <= PCS_RST;
            last_cs_r <= PCS_RST;
            last_vld_r <= 1'b0;
            cs_on_r <= 1'b0;
            sck_r <= 1'b0;
        end
        else if (start)
        begin
            cur_cs_r <= thr_pcs_r;
            cs_on_r <= 1'b1;
            sck_r <= cpol_i[thr_pcs_r];
        end
        else
        begin
            if (tick)
                sck_r <= ~sck_r;
            if (st_r == ST_DONE && fill_if.ready)
            begin
                last_cs_r <= cur_cs_r;
                last_vld_r <= 1'b1;
                cs_on_r <= cs_hold_after_transfer_i[cur_cs_r];
            end
            else if (!enabled_r)
                cs_on_r <= 1'b0;
        end
    end

    // ========================================================
    // Received words; select field copies the holding select at word
    // end, not the pins, so software must not trust it
    assign fill_if.valid = master_mode_i ? (st_r == ST_DONE)
        : (slave_act & word_done);
    assign fill_if.data = {thr_pcs_r, rx_nxt};
    assign fill_if.clr = srst;
    assign drain_if.ready = rx_ready_i;

    spiq_buf2 #(.W(RXW_W)) u_rxbuf (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_if(fill_if),
        .out_if(drain_if)
    );

    // ========================================================
    // Outputs
    assign rx_valid_o = drain_if.valid;
    assign rx_data_o = drain_if.data[DATA_W-1:0];
    assign periph_select_field_o = drain_if.data[RXW_W-1:DATA_W];
    assign tx_holding_empty_flag_o = tx_holding_empty_flag_r;
    assign enabled_o = enabled_r;
    assign mode_fault_o = mode_fault_r;
    assign overrun_o = overrun_r;
    assign busy_o = (st_r != ST_IDLE);
    assign sck_o = sck_r;
    assign mosi_o = shreg_r[DATA_W-1];
    assign miso_o = shreg_r[DATA_W-1];
    assign sck_oe_n_o = ~(master_mode_i & enabled_r);
    assign mosi_oe_n_o = ~(master_mode_i & enabled_r);
    assign miso_oe_n_o = ~slave_act;
    assign chip_select_pins_o = cs_on_r ? ~(NCS'(1) << cur_cs_r) : '1;

    // ========================================================
    // Assertions
    property p_hang;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (hang && st_r == ST_IDLE) |=> st_r == ST_IDLE;
    endproperty
    a_hang: assert property (p_hang) else $error("start while hung");

    property p_dis_flag;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (disable_cmd_i && !srst && !tx_wr_i && !load)
            |=> tx_holding_empty_flag_r == $past(tx_holding_empty_flag_r);
    endproperty
    a_dis_flag: assert property (p_dis_flag) else $error("flag moved");

    property p_wr_off;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (tx_wr_i && !enabled_r && !srst && !load && tx_holding_empty_flag_r) |=> tx_holding_empty_flag_r;
    endproperty
    a_wr_off: assert property (p_wr_off) else $error("write cleared flag");

    property p_dma_lost;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (!enabled_r && tx_wr_i && !srst && !enable_cmd_i)[*2]
            |=> tx_holding_reg_r == $past(tx_holding_reg_r, 2);
    endproperty
    a_dma_lost: assert property (p_dma_lost) else $error("word kept");

    property p_slv_dis;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (disable_cmd_i && !master_mode_i && enabled_r && !srst)
            |=> enabled_r;
    endproperty
    a_slv_dis: assert property (p_slv_dis) else $error("slave disabled");

    property p_srst;
        @(posedge mclk_i) disable iff (!rst_n_i)
        srst |=> tx_holding_empty_flag_r && !enabled_r && !busy_o && (&chip_select_pins_o);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset missed");

    property p_extra;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (start && need_extra && !srst) |=> st_r == ST_EXTRA
            ##1 (st_r == ST_EXTRA)[*1];
    endproperty
    a_extra: assert property (p_extra) else $error("no extra pulse");

    property p_rx_sel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (fill_if.valid && !rx_valid_o && !srst)
            |=> periph_select_field_o == $past(thr_pcs_r);
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("select field");

    property p_sck_tog;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (st_r == ST_SHIFT && tick && !srst && enabled_r)
            |=> sck_o != $past(sck_o);
    endproperty
    a_sck_tog: assert property (p_sck_tog) else $error("sck stuck");

    property p_cs_low;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (start && !srst && !mf_evt) |=> !chip_select_pins_o[cur_cs_r];
    endproperty
    a_cs_low: assert property (p_cs_low) else $error("select not low");

    c_master: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_r == ST_DONE && fill_if.ready);
    c_extra: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_r == ST_EXTRA);
    c_slave: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        slave_act && word_done);
    c_fault: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        mf_evt);
endmodule

/* File: test/spiq_far_model.sv */
// Purpose: Far-side model: serial slave for master runs, master for slave.
// Assumes: Idle-low clock, data sampled on the rising edge.
// Notes: A released data line shows the inverse of its last level.
`timescale 1ns/1ps
module spiq_far_model (
    input wire logic sck_i,
    input wire logic [3:0] cs_n_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    output logic miso_o,
    output logic sck_o,
    output logic mosi_o,
    output logic ss_n_o
);
    logic [7:0] reply_r;
    logic [7:0] got_r;
    logic [7:0] sh_r;
    int edges;
    wire act = ~&cs_n_i;

    initial
    begin
        reply_r = 8'h3c;
        got_r = 8'h00;
        sh_r = 8'h00;
        edges = 0;
        miso_o = 1'b0;
        sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end

    // ==========================================
    // Slave side
    always @(posedge act)
    begin
        sh_r = reply_r;
        miso_o = reply_r[7];
        edges = 0;
    end
    always @(negedge act)
        miso_o = ~miso_o;
    always @(posedge sck_i)
        if (act)
            got_r = {got_r[6:0], mosi_i};
    // Falling edges are counted so a stray pulse shows up
    always @(negedge sck_i)
        if (act)
        begin
            edges = edges + 1;
            sh_r = {sh_r[6:0], 1'b0};
            miso_o = sh_r[7];
        end

    // ==========================================
    // Master side, 160 ns clock period
    task automatic xfer(input logic [7:0] d, output logic [7:0] r);
        int i;
        ss_n_o = 1'b0;
        for (i = 7; i >= 0; i--)
        begin
            mosi_o = d[i];
            #80;
            sck_o = 1'b1;
            r[i] = miso_i;
            #80;
            sck_o = 1'b0;
        end
        #80;
        ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #160;
    endtask
endmodule

/* File: test/spiq_core_tb_top.sv */
// Purpose: Self-checking bench for the SPI controller core.
// Assumes: Commands are one-cycle pulses driven on the falling edge.
// Notes: Select 2 is set up to provoke the stray clock pulse.
`timescale 1ns/1ps
module spiq_core_tb_top;
    import spiq_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic en_c, dis_c, srst, master, mfd, tx_wr, rx_ready;
    logic [3:0] hold, cpol, nph, cs_n;
    logic [31:0] div;
    logic [7:0] tx_data, rx_data;
    logic [1:0] tx_pcs;
    logic flag, enabled, ovr, busy, rx_valid, miso_oe_n, mfault;
    logic [1:0] psel, oe_n;
    logic sck, mosi, miso, ss_n, sck_d, mosi_d, miso_d;
    wire miso_w = miso_oe_n ? 1'b1 : miso_d;
    int bad_count = 0;
    int checks = 0;

    always #2.5 mclk_i = ~mclk_i;

    spiq_core uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .enable_cmd_i(en_c),
        .disable_cmd_i(dis_c), .soft_reset_bit_i(srst),
        .master_mode_i(master), .mode_fault_detect_disable_i(mfd),
        .cs_hold_after_transfer_i(hold), .cpol_i(cpol),
        .inverted_phase_bit_i(nph), .sck_divisor_i(div), .tx_wr_i(tx_wr),
        .tx_data_i(tx_data), .tx_pcs_i(tx_pcs),
        .tx_holding_empty_flag_o(flag), .enabled_o(enabled),
        .mode_fault_o(mfault), .overrun_o(ovr), .busy_o(busy),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .periph_select_field_o(psel), .rx_ready_i(rx_ready), .sck_i(sck),
        .sck_o(sck_d), .sck_oe_n_o(oe_n[1]), .mosi_i(mosi), .mosi_o(mosi_d),
        .mosi_oe_n_o(oe_n[0]), .miso_i(miso), .miso_o(miso_d),
        .miso_oe_n_o(miso_oe_n), .ss_n_i(ss_n), .chip_select_pins_o(cs_n));

    spiq_far_model far (.sck_i(sck_d), .cs_n_i(cs_n), .mosi_i(mosi_d),
        .miso_i(miso_w), .miso_o(miso), .sck_o(sck), .mosi_o(mosi),
        .ss_n_o(ss_n));

    // ==========================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // Code: 1 enable, 2 disable, 4 soft reset
    task automatic cmd(input logic [2:0] k);
        {srst, dis_c, en_c} = k;
        tick(1);
        {srst, dis_c, en_c} = 3'h0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] d, input logic [1:0] p);
        tx_data = d;
        tx_pcs = p;
        tx_wr = 1'b1;
        tick(1);
        tx_wr = 1'b0;
        tick(1);
    endtask
    task automatic run_m();
        int i;
        for (i = 0; i < 20 && busy !== 1'b1; i++)
            tick(1);
        for (i = 0; i < 4000 && busy !== 1'b0; i++)
            tick(1);
        tick(3);
    endtask
    task automatic pop();
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
    endtask
    task automatic complete_run();
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_master();
        cmd(3'h1);
        wr(8'ha5, 2'h1);
        check("master oe_n", oe_n, 2'h0);
        run_m();
        check("mosi byte", far.got_r, 8'ha5);
        check("edge count", far.edges, 8);
        check("rx data", rx_data, 8'h3c);
        check("rx select", psel, 2'h1);
        check("rx valid", rx_valid, 1'b1);
        check("tx empty", flag, 1'b1);
        pop();
    endtask
    task automatic t_extra();
        wr(8'h81, 2'h2);
        run_m();
        check("extra pulse", far.edges, 9);
        pop();
        wr(8'h81, 2'h2);
        run_m();
        check("same select", far.edges, 8);
        pop();
        // Workaround: every divisor one removes the stray pulse
        div = 32'h01010101;
        wr(8'h42, 2'h1);
        run_m();
        pop();
        wr(8'h42, 2'h2);
        run_m();
        check("all divisors one", far.edges, 8);
        pop();
        div = 32'h08010808;
    endtask
    task automatic t_hold();
        cmd(3'h2);
        check("flag at off", flag, 1'b1);
        wr(8'h99, 2'h1);
        check("flag still empty", flag, 1'b1);
        cmd(3'h4);
        mfd = 1'b0;
        hold = 4'h1;
        cmd(3'h1);
        wr(8'h55, 2'h0);
        tick(300);
        check("busy held", busy, 1'b0);
        check("selects", cs_n, 4'hf);
        check("flag held", flag, 1'b0);
        // Feeder stopped above; two idle slots before the disable
        tick(2);
        cmd(3'h2);
        check("enabled", enabled, 1'b0);
        check("flag off", flag, 1'b0);
        // Feeder that missed the disable keeps writing back to back
        tx_wr = 1'b1;
        tx_data = 8'h66;
        tick(1);
        tx_data = 8'h77;
        tick(1);
        tx_wr = 1'b0;
        tick(1);
        check("flag dropped", flag, 1'b0);
        hold = 4'h0;
        mfd = 1'b1;
        cmd(3'h1);
        run_m();
        check("kept word", far.got_r, 8'h55);
        check("flag back", flag, 1'b1);
        pop();
    endtask
    task automatic t_fault();
        mfd = 1'b0;
        cmd(3'h1);
        far.ss_n_o = 1'b0;
        tick(4);
        check("mode fault", mfault, 1'b1);
        check("fault off", enabled, 1'b0);
        far.ss_n_o = 1'b1;
        mfd = 1'b1;
        tick(3);
        cmd(3'h1);
        check("fault cleared", mfault, 1'b0);
        check("on again", enabled, 1'b1);
    endtask
    task automatic t_slave();
        logic [7:0] r;
        cmd(3'h4);
        master = 1'b0;
        cmd(3'h1);
        check("slave oe_n", oe_n, 2'h3);
        wr(8'h5a, 2'h0);
        far.xfer(8'hc3, r);
        check("miso byte", r, 8'h5a);
        rx_ready = 1'b0;
        far.xfer(8'h11, r);
        far.xfer(8'h22, r);
        tick(4);
        check("overrun", ovr, 1'b1);
        check("head", rx_data, 8'hc3);
        pop();
        tick(1);
        check("second", rx_data, 8'h11);
        pop();
        tick(1);
        check("drained", rx_valid, 1'b0);
        cmd(3'h2);
        check("slave on", enabled, 1'b1);
        cmd(3'h4);
        check("reset off", enabled, 1'b0);
        check("reset flag", flag, 1'b1);
        master = 1'b1;
    endtask

    initial
    begin
        {en_c, dis_c, srst, tx_wr, rx_ready} = 5'h0;
        master = 1'b1;
        mfd = 1'b1;
        hold = 4'h0;
        cpol = 4'h4;
        nph = 4'hb;
        div = 32'h08010808;
        tx_data = 8'h00;
        tx_pcs = 2'h0;
        tick(6);
        rst_n_i = 1'b1;
        tick(3);
        t_master();
        t_extra();
        t_hold();
        t_fault();
        t_slave();
        complete_run();
    end

    // Whole run needs well under a third of this span
    initial
    begin
        #300000;
        bad_count++;
        complete_run();
    end
endmodule
